// ### rtl/serial_flash_pin_interface.sv
`timescale 1ns/1ps

// Pin-level serial interface of the flash device.
module serial_flash_pin_interface (
  input wire logic clock,                              // System clock, 10 MHz.
  input wire logic rstn,                               // Reset, active low; synchronous in the system domain, asynchronous in the link domain.
  input wire logic serialClock,                        // Serial clock from the host.
  input wire logic chipSelectN,                        // Chip select, active low.
  input wire logic [3:0] dataLaneIn,                   // Lane pin levels, lanes 3..0.
  output logic [3:0] dataLaneOut,                      // Lane output values.
  output logic [3:0] dataLaneOe,                       // Lane output enables.
  input flash_pin_pkg::lane_mode_t modeReq,            // Lane mode from the decoder.
  input wire logic driveOutReq,                        // Data-out phase from the decoder.
  input flash_pin_pkg::protect_cfg_t protectCfg,       // Status protection bits.
  input wire logic regionProtected,                    // Write target is protected.
  input flash_pin_pkg::write_req_t writeReq,           // Requested writes.
  output flash_pin_pkg::write_req_t writeAllowed,      // Permitted writes.
  input wire logic internalBusy,                       // Internal write cycle running.
  input wire logic txValid,                            // Next output byte offered.
  input wire logic [7:0] txByte,                       // Next output byte.
  output logic txReady,                                // Output byte may be offered.
  output logic rxValid,                                // Received byte, one cycle.
  output logic [7:0] rxByte,                           // Received byte value.
  output logic standby,                                // Deselected and idle.
  output logic active,                                 // Selected.
  output logic holdActive                              // Serial pause in force.
);

  // ----------------------------------------------------------------
  // System-domain declarations
  // ----------------------------------------------------------------

  logic csPrev;                           // Chip select seen last cycle.
  logic armed;                            // Chip select seen high since reset.
  logic frameOk;                          // Current frame may carry instructions.
  logic rxSeen;                           // Receive toggle already handled.
  logic txReq;                            // Transmit request toggle.
  logic [7:0] txWord;                     // Byte offered to the link.
  flash_pin_pkg::lane_mode_t effMode;     // Mode after quad gating.
  logic driveOut;                         // Registered data-out phase.
  logic [4:0] sysSync;                    // Levels brought into the system domain.

  // ----------------------------------------------------------------
  // Link-domain declarations
  // ----------------------------------------------------------------

  logic [2:0] linkSync;                   // Mode and phase in the link domain.
  logic txReqLink;                        // Transmit toggle in the link domain.
  logic [7:0] rxShift;                    // Incoming bits.
  logic [3:0] rxCount;                    // Bits received in this byte.
  logic [7:0] rxHold [2];                 // Two completed bytes, by toggle.
  logic rxToggle;                         // Flips once per completed byte.
  logic [7:0] txShift;                    // Outgoing bits.
  logic [3:0] txCount;                    // Bits sent of this byte.
  logic txAck;                            // Transmit acknowledge toggle.
  logic paused;                           // Pause in force.

  // ----------------------------------------------------------------
  // System-domain decode
  // ----------------------------------------------------------------

  wire csHigh = sysSync[4];               // Synchronised chip select.
  wire wpPin = sysSync[3];                // Synchronised write-protect pin.
  wire rxTogSys = sysSync[2];             // Synchronised receive toggle.
  wire txAckSys = sysSync[1];             // Synchronised acknowledge toggle.
  wire pausedSys = sysSync[0];            // Synchronised pause state.
  wire csFall = csPrev && !csHigh;        // Selection began.
  wire txAccept = txValid && txReady;     // Byte taken from the user.
  wire rxNew = rxTogSys != rxSeen;        // Link finished a byte.
  // Quad is refused unless the quad enable bit is set.
  wire quadOk = (modeReq != flash_pin_pkg::LANE_QUAD) || protectCfg.quadEnable;
  wire flash_pin_pkg::lane_mode_t modeNext = quadOk ? modeReq : flash_pin_pkg::LANE_SINGLE;

  // ----------------------------------------------------------------
  // Synchronisers
  // ----------------------------------------------------------------

  // Pins and link state entering the system domain.
  sync_level #(.WIDTH(5), .RESET_VALUE(5'h18)) u_sys_sync (
    .clock(clock),
    .rstn(rstn),
    .async({chipSelectN, dataLaneIn[2], rxToggle, txAck, paused}),
    .synced(sysSync)
  );

  // Mode and phase entering the link domain.
  sync_level #(.WIDTH(3), .RESET_VALUE(3'h0)) u_link_sync (
    .clock(serialClock),
    .rstn(rstn),
    .async({effMode, driveOut}),
    .synced(linkSync)
  );

  // Transmit request entering the link on the output edge.
  sync_level #(.WIDTH(1), .RESET_VALUE(1'h0)) u_tx_sync (
    .clock(!serialClock),
    .rstn(rstn),
    .async(txReq),
    .synced(txReqLink)
  );

  // ----------------------------------------------------------------
  // Protection
  // ----------------------------------------------------------------

  // The write-protect pin reads high when open, so no lock by default.
  write_protect_gate u_protect (
    .clock(clock),
    .rstn(rstn),
    .wpPin(wpPin),
    .protectCfg(protectCfg),
    .regionProtected(regionProtected),
    .writeReq(writeReq),
    .writeAllowed(writeAllowed)
  );

  // ----------------------------------------------------------------
  // Selection and power state
  // ----------------------------------------------------------------

  // The first frame counts only after chip select has been seen high.
  always_ff @(posedge clock) begin
    if (!rstn) begin
      csPrev <= 1'b0;
      armed <= 1'b0;
      frameOk <= 1'b0;
    end else begin
      csPrev <= csHigh;
      if (csHigh) begin
        armed <= 1'b1;
        frameOk <= 1'b0;
      end else if (csFall) begin
        frameOk <= armed;
      end
    end
  end

  // Standby waits for internal writes; pause does not affect them.
  always_ff @(posedge clock) begin
    if (!rstn) begin
      standby <= 1'b0;
      active <= 1'b0;
      holdActive <= 1'b0;
    end else begin
      standby <= csHigh && !internalBusy;
      active <= !csHigh;
      holdActive <= pausedSys;
    end
  end

  // Mode and phase are registered before crossing.
  always_ff @(posedge clock) begin
    if (!rstn) begin
      effMode <= flash_pin_pkg::LANE_SINGLE;
      driveOut <= 1'b0;
    end else begin
      effMode <= modeNext;
      driveOut <= driveOutReq;
    end
  end

  // ----------------------------------------------------------------
  // Byte exchange with the user
  // ----------------------------------------------------------------

  // Received bytes are passed on only inside an accepted frame.
  always_ff @(posedge clock) begin
    if (!rstn) begin
      rxSeen <= 1'b0;
      rxValid <= 1'b0;
      rxByte <= flash_pin_pkg::BYTE_RESET;
    end else begin
      rxSeen <= rxTogSys;
      rxValid <= rxNew && frameOk;
      if (rxNew) begin
        rxByte <= rxHold[rxSeen];
      end
    end
  end

  // Transmit handshake: the word is held until the link acknowledges.
  always_ff @(posedge clock) begin
    if (!rstn) begin
      txReq <= 1'b0;
      txWord <= flash_pin_pkg::BYTE_RESET;
      txReady <= 1'b0;
    end else if (txAccept) begin
      txReq <= !txReq;
      txWord <= txByte;
      txReady <= 1'b0;
    end else begin
      txReady <= txAckSys == txReq;
    end
  end

  // ----------------------------------------------------------------
  // Link-domain decode
  // ----------------------------------------------------------------

  wire flash_pin_pkg::lane_mode_t linkMode = flash_pin_pkg::lane_mode_t'(linkSync[2:1]);
  wire linkDrive = linkSync[0];
  wire linkQuad = linkMode == flash_pin_pkg::LANE_QUAD;
  wire [3:0] step = flash_pin_pkg::lane_step(linkMode);
  // Hold counts only outside quad; chip select high resets it.
  wire pauseNext = !dataLaneIn[3] && !linkQuad;
  wire rxActive = !linkDrive && !paused;
  wire [3:0] rxCountNext = rxCount + step;
  wire rxDone = rxActive && (rxCountNext == flash_pin_pkg::BYTE_BITS);
  // Single takes lane 0; dual lanes 1..0; quad lanes 3..0.
  wire [7:0] rxShiftNext = linkQuad ? {rxShift[3:0], dataLaneIn} :
    (linkMode == flash_pin_pkg::LANE_DUAL) ? {rxShift[5:0], dataLaneIn[1:0]} :
    {rxShift[6:0], dataLaneIn[0]};
  wire txRun = linkDrive && !pauseNext;
  wire txLoad = txRun && (txCount == flash_pin_pkg::COUNT_RESET);
  wire txFresh = txReqLink != txAck;
  wire [7:0] txSource = txFresh ? txWord : flash_pin_pkg::IDLE_TX_BYTE;
  wire [7:0] txCur = txLoad ? txSource : txShift;
  wire [3:0] txCountNext = txCount + step;
  wire [3:0] laneOutNext = linkQuad ? txCur[7:4] :
    (linkMode == flash_pin_pkg::LANE_DUAL) ? {2'b00, txCur[7:6]} :
    {2'b00, txCur[7], 1'b0};
  // Lanes 2 and 3 are driven only in quad output.
  wire [3:0] laneOeNext = !txRun ? flash_pin_pkg::LANES_OFF :
    linkQuad ? flash_pin_pkg::OE_QUAD :
    (linkMode == flash_pin_pkg::LANE_DUAL) ? flash_pin_pkg::OE_DUAL :
    flash_pin_pkg::OE_SINGLE;

  // ----------------------------------------------------------------
  // Link receive, rising edge
  // ----------------------------------------------------------------

  // Chip select high clears the position, so each frame starts fresh.
  always_ff @(posedge serialClock or posedge chipSelectN or negedge rstn) begin
    if (chipSelectN || !rstn) begin
      rxShift <= flash_pin_pkg::BYTE_RESET;
      rxCount <= flash_pin_pkg::COUNT_RESET;
    end else if (rxActive) begin
      rxShift <= rxShiftNext;
      rxCount <= rxDone ? flash_pin_pkg::COUNT_RESET : rxCountNext;
    end
  end

  // Completed bytes alternate between two slots for the slower reader.
  always_ff @(posedge serialClock or negedge rstn) begin
    if (!rstn) begin
      rxToggle <= 1'b0;
      rxHold[0] <= flash_pin_pkg::BYTE_RESET;
      rxHold[1] <= flash_pin_pkg::BYTE_RESET;
    end else if (rxDone && !chipSelectN) begin
      rxHold[rxToggle] <= rxShiftNext;
      rxToggle <= !rxToggle;
    end
  end

  // ----------------------------------------------------------------
  // Link transmit and pause, falling edge
  // ----------------------------------------------------------------

  // Outputs move only on the falling edge and float when deselected.
  always_ff @(negedge serialClock or posedge chipSelectN or negedge rstn) begin
    if (chipSelectN || !rstn) begin
      paused <= 1'b0;
      txShift <= flash_pin_pkg::BYTE_RESET;
      txCount <= flash_pin_pkg::COUNT_RESET;
      dataLaneOut <= flash_pin_pkg::LANES_OFF;
      dataLaneOe <= flash_pin_pkg::LANES_OFF;
    end else begin
      paused <= pauseNext;
      dataLaneOe <= laneOeNext;
      if (txRun) begin
        dataLaneOut <= laneOutNext;
        txShift <= txCur << step;
        txCount <= (txCountNext == flash_pin_pkg::BYTE_BITS) ?
          flash_pin_pkg::COUNT_RESET : txCountNext;
      end
    end
  end

  // The acknowledge survives deselection so the handshake stays aligned.
  always_ff @(negedge serialClock or negedge rstn) begin
    if (!rstn) begin
      txAck <= 1'b0;
    end else if (txLoad && txFresh && !chipSelectN) begin
      txAck <= txReqLink;
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------

  property p_standby_idle;
    @(posedge clock) disable iff (!rstn)
      standby |-> ($past(csHigh) && !$past(internalBusy));
  endproperty
  a_standby_idle: assert property (p_standby_idle)
    else $error("Standby reported while selected or busy.");

  property p_selected_active;
    @(posedge clock) disable iff (!rstn)
      (!csHigh ##1 !csHigh) |-> active && !standby;
  endproperty
  a_selected_active: assert property (p_selected_active)
    else $error("Selected device not reported active.");

  property p_armed_frame;
    @(posedge clock) disable iff (!rstn)
      rxValid |-> ($past(frameOk) && armed);
  endproperty
  a_armed_frame: assert property (p_armed_frame)
    else $error("Byte delivered before a valid selection edge.");

  property p_quad_gated;
    @(posedge clock) disable iff (!rstn)
      (effMode == flash_pin_pkg::LANE_QUAD) |-> $past(protectCfg.quadEnable);
  endproperty
  a_quad_gated: assert property (p_quad_gated)
    else $error("Quad mode taken without quad enable.");

  property p_pause_floats;
    @(negedge serialClock) disable iff (chipSelectN || !rstn)
      paused |-> (dataLaneOe == flash_pin_pkg::LANES_OFF);
  endproperty
  a_pause_floats: assert property (p_pause_floats)
    else $error("Lane driven during a pause.");

  property p_upper_lanes;
    @(posedge serialClock) disable iff (chipSelectN || !rstn)
      (dataLaneOe[3:2] != 2'b00) |-> linkQuad && linkDrive;
  endproperty
  a_upper_lanes: assert property (p_upper_lanes)
    else $error("Lane 2 or 3 driven outside quad output.");

endmodule

// ### shared/flash_pin_pkg.sv
// Functional notes
// - Chip select high: ignore inputs, float outputs.
// - Deselected and idle means standby; selected means active.
// - No instruction until first chip-select falling edge.
// - Inputs sampled on serial clock rising edge.
// - Outputs change only after serial clock falling edge.
// - Single mode: lane 0 in, lane 1 out.
// - Dual/quad: lanes 0 and 1 bidirectional.
// - Dual moves two bits, quad four per clock.
// - Write-protect low with lock setting blocks status writes.
// - Protected array regions reject program and erase.
// - Quad enable disables the write-protect function.
// - Quad mode: write-protect pin becomes lane 2.
// - Unconnected write-protect and hold read high.
// - Hold pauses only single/dual; quad uses lane 3.
// - Hold acts only while chip select low.
// - Pause begins when serial clock is low.
// - Pause ends when serial clock is low.
// - Pause never stops internal write operations.
// - Paused: outputs float, inputs ignored, position kept.
// - Deselect during pause resets interface state.
// - Quad accepted only with quad enable set.
package flash_pin_pkg;

  // ----------------------------------------------------------------
  // Lane modes and carriers
  // ----------------------------------------------------------------

  // Width of the serial transfer: one, two or four lanes.
  typedef enum logic [1:0] {LANE_SINGLE, LANE_DUAL, LANE_QUAD} lane_mode_t;

  // Protection bits held by the status registers.
  typedef struct packed {
    logic statusProtectHi; // Upper status protect bit.
    logic statusProtectLo; // Lower status protect bit.
    logic quadEnable;      // Non-volatile quad enable bit.
  } protect_cfg_t;

  // A pair of write kinds, used both for requests and permissions.
  typedef struct packed {
    logic statusWrite; // Write to the status registers.
    logic arrayWrite;  // Program or erase of the array.
  } write_req_t;

  // ----------------------------------------------------------------
  // Constants
  // ----------------------------------------------------------------

  localparam logic [3:0] BYTE_BITS = 4'h8;          // Bits in one byte.
  localparam logic [3:0] STEP_SINGLE = 4'h1;        // Bits per clock, single.
  localparam logic [3:0] STEP_DUAL = 4'h2;          // Bits per clock, dual.
  localparam logic [3:0] STEP_QUAD = 4'h4;          // Bits per clock, quad.
  localparam logic [3:0] COUNT_RESET = 4'h0;        // Bit counter after reset.
  localparam logic [7:0] BYTE_RESET = 8'h00;        // Shift registers after reset.
  localparam logic [7:0] IDLE_TX_BYTE = 8'hFF;      // Sent when no byte is ready.
  localparam logic [3:0] LANES_OFF = 4'h0;          // No lane driven.
  localparam logic [3:0] OE_SINGLE = 4'h2;          // Lane 1 driven.
  localparam logic [3:0] OE_DUAL = 4'h3;            // Lanes 0 and 1 driven.
  localparam logic [3:0] OE_QUAD = 4'hF;            // All four lanes driven.
  localparam int DUAL_RATE_MBPS = 216;              // Aggregate dual rate.
  localparam int QUAD_RATE_MBPS = 432;              // Aggregate quad rate.

  // Bits moved per serial clock in a given mode.
  function automatic logic [3:0] lane_step(input lane_mode_t mode);
    case (mode)
      LANE_DUAL: lane_step = STEP_DUAL;
      LANE_QUAD: lane_step = STEP_QUAD;
      default: lane_step = STEP_SINGLE;
    endcase
  endfunction

endpackage

// ### rtl/sync_level.sv
`timescale 1ns/1ps

// Two-stage synchroniser for quasi-static levels and toggles.
module sync_level #(
  parameter int WIDTH = 1,                   // Number of bits carried.
  parameter logic [WIDTH-1:0] RESET_VALUE = '0 // Value held during reset.
) (
  input wire logic clock,              // Destination clock.
  input wire logic rstn,               // Active-low reset.
  input wire logic [WIDTH-1:0] async,  // Level from another domain.
  output logic [WIDTH-1:0] synced      // Level safe to use here.
);

  // First stage, read only by the second stage.
  logic [WIDTH-1:0] stage1;

  // ----------------------------------------------------------------
  // Stages
  // ----------------------------------------------------------------

  // The reset is asynchronous because the link clock may be stopped.
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      stage1 <= RESET_VALUE;
      synced <= RESET_VALUE;
    end else begin
      stage1 <= async;
      synced <= stage1;
    end
  end

endmodule

// ### rtl/write_protect_gate.sv
`timescale 1ns/1ps

// Decides whether status and array writes may go ahead.
module write_protect_gate (
  input wire logic clock,                            // System clock.
  input wire logic rstn,                             // Synchronous reset, active low.
  input wire logic wpPin,                            // Synchronised write-protect pin.
  input flash_pin_pkg::protect_cfg_t protectCfg,     // Protection bits.
  input wire logic regionProtected,                  // Target lies in a protected region.
  input flash_pin_pkg::write_req_t writeReq,         // Requested writes.
  output flash_pin_pkg::write_req_t writeAllowed     // Permitted writes.
);

  // ----------------------------------------------------------------
  // Decode
  // ----------------------------------------------------------------

  // The pin locks the status registers only under the lock setting.
  wire hwLock = !wpPin && !protectCfg.statusProtectHi && protectCfg.statusProtectLo
    && !protectCfg.quadEnable;

  // Protected regions never accept program or erase.
  wire arrayOk = writeReq.arrayWrite && !regionProtected;

  // ----------------------------------------------------------------
  // Permission register
  // ----------------------------------------------------------------

  // Registered so the outputs come straight from flip-flops.
  always_ff @(posedge clock) begin
    if (!rstn) begin
      writeAllowed <= '0;
    end else begin
      writeAllowed.statusWrite <= writeReq.statusWrite && !hwLock;
      writeAllowed.arrayWrite <= arrayOk;
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------

  property p_status_locked;
    @(posedge clock) disable iff (!rstn)
      (!wpPin && !protectCfg.statusProtectHi && protectCfg.statusProtectLo
        && !protectCfg.quadEnable) |=> !writeAllowed.statusWrite;
  endproperty
  a_status_locked: assert property (p_status_locked)
    else $error("Status write allowed under hardware lock.");

  property p_region_blocked;
    @(posedge clock) disable iff (!rstn)
      regionProtected |=> !writeAllowed.arrayWrite;
  endproperty
  a_region_blocked: assert property (p_region_blocked)
    else $error("Array write allowed in a protected region.");

  property p_quad_frees_pin;
    @(posedge clock) disable iff (!rstn)
      (protectCfg.quadEnable && writeReq.statusWrite) |=> writeAllowed.statusWrite;
  endproperty
  a_quad_frees_pin: assert property (p_quad_frees_pin)
    else $error("Status write refused although quad enable is set.");

endmodule

// ### tb/spi_host_model.sv
`timescale 1ns/1ps

// Host controller model in clock mode 3; its clock stands high outside frames.
module spi_host_model (
  output logic sclk, // Serial clock.
  output logic csN, // Chip select, active low.
  output logic [3:0] hOut, // Lane values.
  output logic [3:0] hOe, // Lane enables.
  input wire logic [3:0] laneIn // Resolved lanes.
);
  initial begin
    sclk = 1'b1;
    csN = 1'b1;
    hOut = 4'h0;
    hOe = 4'h0;
  end
  // One frame, MSB first: lanes change on falling edges, lane 1 is read on rising.
  task automatic xfer(input logic [7:0] tx, input int st, input logic rd,
                      output logic [7:0] rx);
    csN = 1'b0;
    #200;
    for (int b = 7; b >= 0; b -= st) begin
      sclk = 1'b0;
      hOut = st == 4 ? tx[b -: 4] : st == 2 ? {2'h0, tx[b -: 2]} : {3'h0, tx[b]};
      hOe = rd ? 4'h0 : st == 4 ? 4'hF : st == 2 ? 4'h3 : 4'h1;
      #62.5 sclk = 1'b1;
      rx = {rx[6:0], laneIn[1]};
      #62.5;
    end
    csN = 1'b1;
    hOe = 4'h0;
    #500;
  endtask
  // A cut frame of two clocks, so new mode, phase and byte offers reach the link first.
  task automatic prime;
    csN = 1'b0;
    #200;
    repeat (2) begin
      sclk = 1'b0;
      #62.5 sclk = 1'b1;
      #62.5;
    end
    csN = 1'b1;
    #500;
  endtask
endmodule

// ### tb/serial_flash_pin_interface_bench.sv
`timescale 1ns/1ps
`define CHK(a, b) begin cmp_count++; if ((a) !== (b)) begin failures++; \
  $display("Error at %0t: mismatch", $time); end end

// Self-checking bench for the flash pin interface.
module serial_flash_pin_interface_bench;
  logic clock, rstn, wpLow, holdLow, drv, regProt, busy, txValid, sclk, csN;
  logic txReady, rxValid, standby, active, hold;
  logic [3:0] hOut, hOe, laneIn, dOut, dOe;
  logic [7:0] txByte, rxByte, got;
  flash_pin_pkg::lane_mode_t modeReq;
  flash_pin_pkg::protect_cfg_t cfg;
  flash_pin_pkg::write_req_t wReq, wOk;
  int failures = 0;
  int cmp_count = 0;
  // Device wins, then host; else pull-ups on lanes 3..2, flipped last value on 1..0.
  assign laneIn = (dOe & dOut) | (~dOe & hOe & hOut)
    | (~dOe & ~hOe & {!holdLow, !wpLow, ~hOut[1:0]});
  spi_host_model i_host (.sclk(sclk), .csN(csN), .hOut(hOut), .hOe(hOe), .laneIn(laneIn));
  serial_flash_pin_interface i_dut (.clock(clock), .rstn(rstn), .serialClock(sclk),
    .chipSelectN(csN), .dataLaneIn(laneIn), .dataLaneOut(dOut), .dataLaneOe(dOe),
    .modeReq(modeReq), .driveOutReq(drv), .protectCfg(cfg), .regionProtected(regProt),
    .writeReq(wReq), .writeAllowed(wOk), .internalBusy(busy), .txValid(txValid),
    .txByte(txByte), .txReady(txReady), .rxValid(rxValid), .rxByte(rxByte),
    .standby(standby), .active(active), .holdActive(hold));
  initial begin
    clock = 1'b0;
    forever #50 clock = ~clock;
  end
  task automatic print_verdict;
    if (failures == 0 && cmp_count > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  // Sends one byte in the given lane mode and checks the byte delivered.
  task automatic rx_frame(input flash_pin_pkg::lane_mode_t m, input int st,
                          input logic [7:0] v);
    @(posedge clock) modeReq <= m;
    repeat (5) @(posedge clock);
    i_host.prime();
    fork
      i_host.xfer(v, st, 1'b0, got);
      begin
        for (int n = 0; n < 40 && rxValid !== 1'b1; n++) @(negedge clock);
        `CHK(rxValid, 1'b1)
        `CHK(rxByte, v)
      end
    join
  endtask
  // Offers a byte and reads it back on lane 1.
  task automatic tx_single;
    @(posedge clock) drv <= 1'b1;
    for (int n = 0; n < 20 && txReady !== 1'b1; n++) @(negedge clock);
    @(posedge clock) txValid <= 1'b1;
    txByte <= 8'h96;
    @(posedge clock) txValid <= 1'b0;
    repeat (4) @(posedge clock);
    i_host.prime();
    i_host.xfer(8'h00, 1, 1'b1, got);
    `CHK(got, 8'h96)
    `CHK(dOe, flash_pin_pkg::LANES_OFF)
    `CHK(txReady, 1'b1)
    @(posedge clock) drv <= 1'b0;
  endtask
  // Walks pin level, quad enable and region protection.
  task automatic protect;
    for (int i = 0; i < 4; i++) begin
      @(posedge clock) cfg <= {1'b0, 1'b1, i[0]};
      wpLow <= !i[1];
      regProt <= i[0];
      wReq <= 2'h3;
      repeat (6) @(negedge clock);
      `CHK(wOk.statusWrite, i[1] | i[0])
      `CHK(wOk.arrayWrite, !i[0])
    end
    @(posedge clock) wpLow <= 1'b0;
  endtask
  // Standby follows the internal write cycle; selection means active; hold pauses the link.
  task automatic power;
    @(posedge clock) busy <= 1'b1;
    holdLow <= 1'b1;
    repeat (5) @(negedge clock);
    `CHK(standby, 1'b0)
    fork
      i_host.xfer(8'h00, 1, 1'b0, got);
      begin
        #800;
        `CHK(active, 1'b1)
        `CHK(hold, 1'b1)
        `CHK(dOe, flash_pin_pkg::LANES_OFF)
      end
    join
    @(posedge clock) busy <= 1'b0;
    repeat (5) @(negedge clock);
    `CHK(standby, 1'b1)
    `CHK(hold, 1'b0)
    @(posedge clock) holdLow <= 1'b0;
  endtask
  initial begin
    rstn = 1'b0;
    {wpLow, holdLow, drv, regProt, busy, txValid} = 6'h00;
    txByte = 8'h00;
    modeReq = flash_pin_pkg::LANE_SINGLE;
    cfg = 3'h0;
    wReq = 2'h0;
    repeat (16) @(posedge clock);
    rstn <= 1'b1;
    repeat (5) @(posedge clock);
    rx_frame(flash_pin_pkg::LANE_SINGLE, 1, 8'hA5);
    rx_frame(flash_pin_pkg::LANE_DUAL, 2, 8'h3C);
    @(posedge clock) cfg <= 3'h1;
    rx_frame(flash_pin_pkg::LANE_QUAD, 4, 8'hC3);
    rx_frame(flash_pin_pkg::LANE_SINGLE, 1, 8'h5A);
    tx_single();
    protect();
    power();
    print_verdict();
  end
  // Cuts a hang short well after the expected run time.
  initial begin
    #200000;
    failures++;
    print_verdict();
  end
endmodule
